// ### inc/gifc_pkg.sv
// package of shared constants and types for the gated frequency counter
// assumes a 10 MHz system clock on both ends
`default_nettype none
package gifc_pkg;

    // ========================================
    // clock and timebase
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned TIMEBASE_HZ   = 2_000_000;
    localparam int unsigned TB_DIV        = CLK_HZ / TIMEBASE_HZ;
    localparam logic [2:0]  TB_DIV_LAST   = 3'(TB_DIV - 1);

    // ========================================
    // gate windows, in milliseconds
    localparam int unsigned GATE_10HZ_MS  = 200;
    localparam int unsigned GATE_100HZ_MS = 20;
    localparam int unsigned GATE_FAST_MS  = 2;
    localparam int unsigned GATE_10HZ_TK  = GATE_10HZ_MS * (TIMEBASE_HZ / 1000);
    localparam int unsigned GATE_100HZ_TK = GATE_100HZ_MS * (TIMEBASE_HZ / 1000);
    localparam int unsigned GATE_FAST_TK  = GATE_FAST_MS * (TIMEBASE_HZ / 1000);

    // ========================================
    // widths and reset values
    localparam int unsigned PRE_W         = 8;
    localparam int unsigned NIB_W         = 4;
    localparam int unsigned TMR_W         = 16;
    localparam int unsigned GATE_W        = 20;
    localparam logic [PRE_W-1:0] PRE_RST  = 8'h00;
    localparam logic [TMR_W-1:0] TMR_RST  = 16'h0000;
    localparam logic [GATE_W-1:0] GATE_RST = 20'h00000;

    // ========================================
    // counter resolution selections
    typedef enum logic [2:0] {
        GIFC_RES_10HZ,
        GIFC_RES_100HZ,
        GIFC_RES_1KHZ,
        GIFC_RES_10KHZ,
        GIFC_RES_100KHZ,
        GIFC_RES_1MHZ
    } gifc_res_e;

    function automatic logic [GATE_W-1:0] gifc_gate_ticks(input gifc_res_e r);
        unique case (r)
            GIFC_RES_10HZ:  gifc_gate_ticks = GATE_W'(GATE_10HZ_TK);
            GIFC_RES_100HZ: gifc_gate_ticks = GATE_W'(GATE_100HZ_TK);
            GIFC_RES_1KHZ:  gifc_gate_ticks = GATE_W'(GATE_100HZ_TK);
            default:        gifc_gate_ticks = GATE_W'(GATE_FAST_TK);
        endcase
    endfunction

endpackage
`default_nettype wire

// ### inc/gifc_if.sv
// interface joining the counter device and the host cpu
// assumes both ends share clock_i; the bus has no tristate
`timescale 1ns/1ps
`default_nettype none
interface gifc_if;
    import gifc_pkg::*;
    logic                 count_overflow_irq;
    logic                 measure_done_irq;
    logic                 gate_window_pulse;
    logic                 done_irq_ack;
    logic                 prescaler_read_n;
    logic                 timer_select_n;
    logic                 timer_read_n;
    logic [TMR_W-1:0]     cpu_data_bus;
    logic                 cpu_data_oe;

    modport dev (
        output count_overflow_irq,
        output measure_done_irq,
        output gate_window_pulse,
        output cpu_data_bus,
        output cpu_data_oe,
        input  done_irq_ack,
        input  prescaler_read_n,
        input  timer_select_n,
        input  timer_read_n
    );
    modport cpu (
        input  count_overflow_irq,
        input  measure_done_irq,
        input  gate_window_pulse,
        input  cpu_data_bus,
        input  cpu_data_oe,
        output done_irq_ack,
        output prescaler_read_n,
        output timer_select_n,
        output timer_read_n
    );
endinterface
`default_nettype wire

// ### design/gifc_device.sv
// gated if frequency counter, device end
// assumes if_count_i is the halved if from an external pin
//
// Overview of operation
// - divide 10 MHz reference by five
// - timebase clocks gate timer, makes window
// - window length follows counter resolution
// - window 200 ms, 20 ms, 2 ms
// - gated input drives two nibble stages
// - prescaler msb clocks count timer
// - count timer overflow sets overflow irq
// - gate end sets done irq when ack high
// - prescaler read strobe drives byte out
// - select and read drive timer word
// - host clears done via ack low
// - input is halved if, counted as-is
`timescale 1ns/1ps
`default_nettype none
module gifc_device
    import gifc_pkg::*;
(
    input  wire logic      clock_i,
    input  wire logic      rst_n_i,
    input  wire logic      if_count_i,
    input  wire logic      start_i,
    input  wire gifc_res_e resolution_i,
    gifc_if.dev            bus
);

    // ========================================
    // state
    localparam int unsigned NSTG = PRE_W / NIB_W;
    typedef logic [NSTG-1:0][NIB_W-1:0] gifc_nib_t;

    typedef enum logic [1:0] {
        GIFC_IDLE,
        GIFC_GATE,
        GIFC_HOLD
    } gifc_st_e;

    typedef struct packed {
        gifc_st_e          st;
        logic [2:0]        tb_cnt;
        logic [GATE_W-1:0] gate_cnt;
        logic              gate;
        logic              in_s1;
        logic              in_s2;
        logic              in_s3;
        gifc_nib_t         nib;
        logic              msb_prev;
        logic [TMR_W-1:0]  tmr;
        logic              ovf_out;
        logic              ovf_irq;
        logic              done_irq;
        logic [TMR_W-1:0]  dout;
        logic              doe;
    } gifc_dev_s;

    gifc_dev_s s_q;
    gifc_dev_s s_d;
    logic             tb_tick;
    logic             in_rise;
    logic             msb_fall;
    logic [PRE_W-1:0] pre;
    logic [NSTG:0]    stg_en;
    gifc_nib_t        nib_nx;

    // ========================================
    // timebase and input edge
    // divide by five
    assign tb_tick = (s_q.tb_cnt == TB_DIV_LAST);
    assign in_rise = s_q.in_s2 & ~s_q.in_s3 & s_q.gate;

    // ========================================
    // prescaler stages
    assign pre       = s_q.nib;
    assign stg_en[0] = in_rise;
    genvar g;
    generate
        for (g = 0; g < NSTG; g++) begin : g_stg
            assign nib_nx[g]   = stg_en[g] ? s_q.nib[g] + 4'h1 : s_q.nib[g];
            assign stg_en[g+1] = stg_en[g] & (s_q.nib[g] == 4'hF);
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        s_d.tb_cnt = tb_tick ? 3'h0 : s_q.tb_cnt + 3'h1;

        // ========================================
        // pin synchroniser
        // sample halved if
        s_d.in_s1 = if_count_i;
        s_d.in_s2 = s_q.in_s1;
        s_d.in_s3 = s_q.in_s2;
        s_d.nib = nib_nx;
        s_d.msb_prev = pre[PRE_W-1];
        s_d.ovf_out = 1'b0;

        // ========================================
        // gate timer
        unique case (s_q.st)
            GIFC_IDLE: begin
                if (start_i && tb_tick) begin
                    s_d.st = GIFC_GATE;
                    s_d.gate = 1'b1;
                    s_d.gate_cnt = gifc_gate_ticks(resolution_i);
                    s_d.nib = PRE_RST;
                    s_d.msb_prev = 1'b0;
                    s_d.tmr = TMR_RST;
                    s_d.ovf_out = 1'b0;
                end
            end
            GIFC_GATE: begin
                if (tb_tick) begin
                    s_d.gate_cnt = s_q.gate_cnt - GATE_W'(1);
                    if (s_q.gate_cnt == GATE_W'(1)) begin
                        s_d.gate = 1'b0;
                        s_d.st = GIFC_HOLD;
                        if (bus.done_irq_ack) begin
                            s_d.done_irq = 1'b1;
                        end
                    end
                end
            end
            GIFC_HOLD: begin
                if (!start_i) begin
                    s_d.st = GIFC_IDLE;
                end
            end
            default: s_d.st = GIFC_IDLE;
        endcase

        // ========================================
        // count timer
        // msb fall clocks timer
        msb_fall = s_q.msb_prev & ~pre[PRE_W-1];
        if (msb_fall) begin
            s_d.tmr = s_q.tmr + 16'h0001;
            if (s_q.tmr == 16'hFFFF) begin
                s_d.ovf_out = 1'b1;
            end
        end

        // ========================================
        // interrupt flip-flops
        // timer output sets irq
        if (s_q.ovf_out) begin
            s_d.ovf_irq = 1'b1;
        end else if (!bus.done_irq_ack) begin
            s_d.ovf_irq = 1'b0;
        end
        if (!bus.done_irq_ack) begin
            s_d.done_irq = 1'b0;
        end

        // ========================================
        // read drivers
        // prescaler byte read
        s_d.doe = 1'b0;
        s_d.dout = 16'h0000;
        if (!bus.prescaler_read_n) begin
            s_d.doe = 1'b1;
            s_d.dout = {8'h00, pre};
        end else if (!bus.timer_select_n && !bus.timer_read_n) begin
            s_d.doe = 1'b1;
            s_d.dout = s_q.tmr;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================
    // outputs
    // overflow irq flop
    assign bus.count_overflow_irq = s_q.ovf_irq;
    assign bus.measure_done_irq   = s_q.done_irq;
    assign bus.gate_window_pulse  = s_q.gate;
    assign bus.cpu_data_bus       = s_q.dout;
    assign bus.cpu_data_oe        = s_q.doe;

endmodule
`default_nettype wire

// ### design/gifc_host.sv
// host cpu end: reads prescaler and timer, then acknowledges
// assumes device answers a read one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module gifc_host
    import gifc_pkg::*;
(
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    gifc_if.cpu                   bus,
    output logic [PRE_W-1:0]      pre_byte_o,
    output logic [TMR_W-1:0]      tmr_word_o,
    output logic [PRE_W+TMR_W-1:0] total_o,
    output logic                  result_valid_o,
    output logic                  overflow_o
);

    typedef enum logic [2:0] {
        GIFC_H_WAIT,
        GIFC_H_RDP,
        GIFC_H_RDT,
        GIFC_H_ACK,
        GIFC_H_REL
    } gifc_hst_e;

    typedef struct packed {
        gifc_hst_e             st;
        logic                  ack;
        logic                  prd_n;
        logic                  sel_n;
        logic                  rd_n;
        logic [1:0]            wt;
        logic [PRE_W-1:0]      pre;
        logic [TMR_W-1:0]      tmr;
        logic [PRE_W+TMR_W-1:0] tot;
        logic                  vld;
        logic                  ovf;
    } gifc_host_s;

    gifc_host_s h_q;
    gifc_host_s h_d;

    always_comb begin
        h_d = h_q;
        h_d.vld = 1'b0;
        h_d.ovf = h_q.ovf | bus.count_overflow_irq;
        unique case (h_q.st)
            GIFC_H_WAIT: begin
                h_d.ack = 1'b1;
                if (bus.measure_done_irq) begin
                    h_d.st = GIFC_H_RDP;
                    h_d.prd_n = 1'b0;
                    h_d.wt = 2'h0;
                end
            end
            GIFC_H_RDP: begin
                h_d.wt = h_q.wt + 2'h1;
                if (h_q.wt == 2'h2) begin
                    h_d.pre = bus.cpu_data_bus[PRE_W-1:0];
                    h_d.prd_n = 1'b1;
                    h_d.sel_n = 1'b0;
                    h_d.rd_n = 1'b0;
                    h_d.wt = 2'h0;
                    h_d.st = GIFC_H_RDT;
                end
            end
            GIFC_H_RDT: begin
                h_d.wt = h_q.wt + 2'h1;
                if (h_q.wt == 2'h2) begin
                    h_d.tmr = bus.cpu_data_bus;
                    h_d.sel_n = 1'b1;
                    h_d.rd_n = 1'b1;
                    h_d.st = GIFC_H_ACK;
                end
            end
            GIFC_H_ACK: begin
                h_d.tot = {h_q.tmr, h_q.pre};
                h_d.vld = 1'b1;
                h_d.ack = 1'b0;
                h_d.wt = 2'h0;
                h_d.st = GIFC_H_REL;
            end
            GIFC_H_REL: begin
                h_d.wt = h_q.wt + 2'h1;
                if (h_q.wt == 2'h3 && !bus.measure_done_irq) begin
                    h_d.ack = 1'b1;
                    h_d.ovf = 1'b0;
                    h_d.st = GIFC_H_WAIT;
                end
            end
            default: h_d.st = GIFC_H_WAIT;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            h_q <= '{st: GIFC_H_WAIT, ack: 1'b1, prd_n: 1'b1,
                     sel_n: 1'b1, rd_n: 1'b1, default: '0};
        end else begin
            h_q <= h_d;
        end
    end

    assign bus.done_irq_ack     = h_q.ack;
    assign bus.prescaler_read_n = h_q.prd_n;
    assign bus.timer_select_n   = h_q.sel_n;
    assign bus.timer_read_n     = h_q.rd_n;
    assign pre_byte_o           = h_q.pre;
    assign tmr_word_o           = h_q.tmr;
    assign total_o              = h_q.tot;
    assign result_valid_o       = h_q.vld;
    assign overflow_o           = h_q.ovf;

endmodule
`default_nettype wire

// ### bench/gifc_chk.sv
// checker of the counter bus, irqs and gate window
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module gifc_chk
    import gifc_pkg::*;
(
    input wire logic             clock_i,
    input wire logic             rst_n_i,
    input wire logic             count_overflow_irq,
    input wire logic             measure_done_irq,
    input wire logic             gate_window_pulse,
    input wire logic             done_irq_ack,
    input wire logic             prescaler_read_n,
    input wire logic             timer_select_n,
    input wire logic             timer_read_n,
    input wire logic [TMR_W-1:0] cpu_data_bus,
    input wire logic             cpu_data_oe
);
    // ========================================
    // window length counter
    localparam int W1 = GATE_FAST_TK * TB_DIV;
    localparam int W2 = GATE_100HZ_TK * TB_DIV;
    localparam int W3 = GATE_10HZ_TK * TB_DIV;
    logic [23:0] win_q;
    logic        rd_on;
    logic        tm_on;
    assign tm_on = !timer_select_n && !timer_read_n;
    assign rd_on = !prescaler_read_n || tm_on;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !gate_window_pulse) begin
            win_q <= 24'h000000;
        end else begin
            win_q <= win_q + 24'h000001;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // ========================================
    // properties
    property p_pre_oe;
        $fell(prescaler_read_n) |=> cpu_data_oe;
    endproperty
    a_pre_oe: assert property (p_pre_oe)
        else $error("bus not driven after prescaler strobe");
    property p_pre_byte;
        !prescaler_read_n && $past(!prescaler_read_n)
            |-> cpu_data_oe && cpu_data_bus[15:8] == 8'h00;
    endproperty
    a_pre_byte: assert property (p_pre_byte)
        else $error("prescaler byte not alone on bus");
    property p_tmr_oe;
        tm_on && $past(tm_on) && prescaler_read_n && $past(prescaler_read_n)
            |-> cpu_data_oe;
    endproperty
    a_tmr_oe: assert property (p_tmr_oe)
        else $error("bus not driven for timer read");
    property p_oe_cause;
        cpu_data_oe |-> $past(rd_on) || $past(rd_on, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("bus driven without strobe");
    property p_done_set;
        $fell(gate_window_pulse) && done_irq_ack |-> ##[0:1] measure_done_irq;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("done irq missing after window");
    property p_done_cause;
        $rose(measure_done_irq) |-> !gate_window_pulse
            && ($past(gate_window_pulse) || $past(gate_window_pulse, 2));
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("done irq without window end");
    property p_done_hold;
        measure_done_irq && done_irq_ack |=> measure_done_irq;
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("done irq dropped while ack high");
    property p_ack_clear;
        !done_irq_ack && $past(!done_irq_ack) && !gate_window_pulse
            && !$past(gate_window_pulse)
            |-> !measure_done_irq && !count_overflow_irq;
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("irq not cleared by ack low");
    property p_gate_len;
        $fell(gate_window_pulse) |-> win_q == 24'(W1) || win_q == 24'(W2)
            || win_q == 24'(W3);
    endproperty
    a_gate_len: assert property (p_gate_len)
        else $error("gate window length wrong");
    c_done: cover property ($rose(measure_done_irq));
    c_pre: cover property ($fell(prescaler_read_n));
    c_tmr: cover property (tm_on && cpu_data_oe);
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// testbench joining device and host through the interface
// assumes 10 MHz clock, inputs driven on falling edges
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import gifc_pkg::*;
;
    localparam int WIN = GATE_FAST_TK * TB_DIV;
    logic                   clock_i;
    logic                   rst_n_i;
    logic                   if_count_i;
    logic                   start_i;
    gifc_res_e              resolution_i;
    logic [PRE_W-1:0]       pre_byte;
    logic [TMR_W-1:0]       tmr_word;
    logic [PRE_W+TMR_W-1:0] total;
    logic                   result_valid;
    logic                   overflow;
    int                     bad_count = 0;
    int                     samples_checked = 0;
    int                     half_q = 0;
    int                     ph = 0;
    gifc_if bus_if ();
    gifc_device i_gifc_device (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .if_count_i(if_count_i),
        .start_i(start_i), .resolution_i(resolution_i), .bus(bus_if.dev));
    gifc_host i_gifc_host (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .bus(bus_if.cpu),
        .pre_byte_o(pre_byte), .tmr_word_o(tmr_word), .total_o(total),
        .result_valid_o(result_valid), .overflow_o(overflow));
    gifc_chk i_chk (
        .clock_i(clock_i), .rst_n_i(rst_n_i),
        .count_overflow_irq(bus_if.count_overflow_irq),
        .measure_done_irq(bus_if.measure_done_irq),
        .gate_window_pulse(bus_if.gate_window_pulse),
        .done_irq_ack(bus_if.done_irq_ack),
        .prescaler_read_n(bus_if.prescaler_read_n),
        .timer_select_n(bus_if.timer_select_n),
        .timer_read_n(bus_if.timer_read_n),
        .cpu_data_bus(bus_if.cpu_data_bus), .cpu_data_oe(bus_if.cpu_data_oe));
    // ========================================
    // clock and counted input
    initial begin
        clock_i = 1'h0;
        forever #50 clock_i = ~clock_i;
    end
    always @(negedge clock_i) begin
        ph++;
        if (half_q != 0 && ph >= half_q) begin
            ph = 0;
            if_count_i = ~if_count_i;
        end
    end
    // ========================================
    // compares and closing
    task automatic check_bit(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_num(input string n, input logic [23:0] e,
                             input logic [23:0] g, input int tol);
        int d;
        samples_checked++;
        d = int'(g) - int'(e);
        if (^g === 1'hx || d > tol || -d > tol) begin
            bad_count++;
            $display("FAIL %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wait_until(input string n, input int sel, input int lim);
        int k;
        k = 0;
        while ((sel == 0 ? bus_if.gate_window_pulse : result_valid) !== 1'h1)
        begin
            @(negedge clock_i);
            k++;
            if (k > lim) begin
                bad_count++;
                $display("FAIL %s expected event seen timeout", n);
                results();
            end
        end
    endtask
    // ========================================
    // scenarios
    task automatic measure(input gifc_res_e r, input int h, input string n);
        int len;
        logic seen;
        len = 0;
        seen = 1'h0;
        half_q = h;
        resolution_i = r;
        start_i = 1'h1;
        wait_until(n, 0, 40);
        while (bus_if.gate_window_pulse === 1'h1 && len <= WIN + 10) begin
            @(negedge clock_i);
            len++;
        end
        check_num({n, " window"}, 24'(WIN), 24'(len), 0);
        @(negedge clock_i);
        check_bit({n, " done irq"}, 1'h1, bus_if.measure_done_irq);
        wait_until(n, 1, 60);
        check_num({n, " total"}, 24'(h == 0 ? 0 : WIN / (2 * h)), total,
                  h == 0 ? 0 : 2);
        check_num({n, " sum"}, {tmr_word, pre_byte}, total, 0);
        check_bit({n, " overflow"}, 1'h0, overflow);
        repeat (100) begin
            @(negedge clock_i);
            seen = seen | bus_if.gate_window_pulse;
        end
        check_bit({n, " rearm"}, 1'h0, seen);
        check_bit({n, " ack back"}, 1'h1, bus_if.done_irq_ack);
        check_bit({n, " done clear"}, 1'h0, bus_if.measure_done_irq);
        start_i = 1'h0;
        @(negedge clock_i);
    endtask
    task automatic reset_mid;
        half_q = 1;
        resolution_i = GIFC_RES_10KHZ;
        start_i = 1'h1;
        wait_until("abort", 0, 40);
        repeat (100) @(negedge clock_i);
        rst_n_i = 1'h0;
        half_q = 0;
        repeat (3) @(negedge clock_i);
        check_bit("abort gate", 1'h0, bus_if.gate_window_pulse);
        check_bit("abort done", 1'h0, bus_if.measure_done_irq);
        check_bit("abort bus", 1'h0, bus_if.cpu_data_oe);
        start_i = 1'h0;
        rst_n_i = 1'h1;
        @(negedge clock_i);
    endtask
    initial begin
        rst_n_i = 1'h0;
        start_i = 1'h0;
        if_count_i = 1'h0;
        resolution_i = GIFC_RES_10KHZ;
        repeat (12) @(negedge clock_i);
        rst_n_i = 1'h1;
        measure(GIFC_RES_10KHZ, 3, "res_10k");
        measure(GIFC_RES_100KHZ, 1, "res_100k");
        reset_mid();
        measure(GIFC_RES_1MHZ, 0, "res_1m");
        results();
    end
endmodule
`default_nettype wire
